// *** core/i2c_target_pkg.sv ***
/*
 Constants, state encoding and register map of the serial control target.
 Assumes a 40 MHz core clock and an open-drain two-wire link.
*/
//---------------------------------------------------------------------------
// Summary of operation
//---------------------------------------------------------------------------
package i2c_target_pkg;

   //------------------------------------------------------------------------
   // Link constants
   //------------------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR      = 7'h4c;
   localparam logic [3:0] BYTE_BITS     = 4'h8;
   localparam logic       DIR_READ      = 1'b1;

   //------------------------------------------------------------------------
   // Register map
   //------------------------------------------------------------------------
   localparam logic [7:0] REG_SELF_TEST = 8'h0c;
   localparam logic [7:0] SELF_TEST_GO  = 8'h01;
   localparam logic [7:0] REG_RESET     = 8'h00;
   localparam int         REG_COUNT     = 16;

   // Self-test status byte layout
   localparam int         ST_DONE_BIT   = 7;
   localparam int         ST_RUN_BIT    = 6;
   localparam int         LED_COUNT     = 5;
   localparam int         STEP_EDGES    = 8;

   //------------------------------------------------------------------------
   // Timing
   //------------------------------------------------------------------------
   localparam int         CLK_PERIOD_NS = 25;
   localparam int         HOLD_MIN_NS   = 300;
   localparam int         HOLD_CYC      =
      (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   //------------------------------------------------------------------------
   // Serial state machine
   //------------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_ADDR      = 4'h1,
      ST_ADDR_ACK  = 4'h3,
      ST_REG       = 4'h2,
      ST_REG_ACK   = 4'h6,
      ST_WDATA     = 4'h7,
      ST_WDATA_ACK = 4'h5,
      ST_RDATA     = 4'h4,
      ST_RDATA_ACK = 4'hc,
      ST_IGNORE    = 4'hd
   } link_state_type;

endpackage : i2c_target_pkg

// *** core/sync_two_ff.sv ***
/*
 Two-flop synchroniser for a group of independent level inputs.
 Assumes each bit is a slow level; no bus coherency across bits.
*/
`timescale 1ns/10ps
module sync_two_ff #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_ff <= RESET_VAL;
         sync_ff <= RESET_VAL;
      end else begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end

   assign o_sync = sync_ff;

endmodule : sync_two_ff

// *** core/led_self_test.sv ***
/*
 LED connectivity self-test sequencer: one sink enabled at a time,
 path result captured at the end of each slot.
 Assumes i_step is a one-cycle pulse per link clock rising edge and
 i_led_ok is already synchronised.
*/
`timescale 1ns/10ps
module led_self_test #(
   parameter int LEDS  = i2c_target_pkg::LED_COUNT,
   parameter int STEPS = i2c_target_pkg::STEP_EDGES
) (
   input  wire logic            i_clk,
   input  wire logic            i_rst,
   input  wire logic            i_start,
   input  wire logic            i_step,
   input  wire logic [LEDS-1:0] i_led_ok,
   output logic      [LEDS-1:0] o_sink_en,
   output logic      [7:0]      o_status
);

   localparam int IW = $clog2(LEDS + 1);
   localparam int CW = $clog2(STEPS + 1);

   logic            run_ff;
   logic            done_ff;
   logic [IW-1:0]   idx_ff;
   logic [CW-1:0]   cnt_ff;
   logic [LEDS-1:0] pass_ff;
   logic [LEDS-1:0] sink_ff;
   logic [7:0]      status_w;
   wire             slot_end = run_ff & i_step &
                               (cnt_ff == CW'(STEPS - 1));
   wire             last_led = (idx_ff == IW'(LEDS - 1));

   //------------------------------------------------------------------------
   // Slot sequencing
   //------------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         run_ff  <= 1'b0;
         done_ff <= 1'b0;
         idx_ff  <= '0;
         cnt_ff  <= '0;
      end else if (i_start) begin
         run_ff  <= 1'b1;
         done_ff <= 1'b0;
         idx_ff  <= '0;
         cnt_ff  <= '0;
      end else if (slot_end) begin
         cnt_ff  <= '0;
         idx_ff  <= last_led ? '0 : idx_ff + IW'(1);
         run_ff  <= ~last_led;
         done_ff <= last_led;
      end else if (run_ff && i_step) begin
         cnt_ff  <= cnt_ff + CW'(1);
      end
   end

   //------------------------------------------------------------------------
   // Per-LED sink drive and result capture
   //------------------------------------------------------------------------
   for (genvar g = 0; g < LEDS; g++) begin : g_led
      wire sel = run_ff & (idx_ff == IW'(g));
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            pass_ff[g] <= 1'b0;
            sink_ff[g] <= 1'b0;
         end else begin
            sink_ff[g] <= sel & ~(slot_end & last_led) & ~i_start;
            if (i_start) begin
               pass_ff[g] <= 1'b0;
            end else if (slot_end && sel) begin
               pass_ff[g] <= i_led_ok[g];
            end
         end
      end
   end

   always_comb begin
      status_w                             = 8'h00;
      status_w[i2c_target_pkg::ST_DONE_BIT] = done_ff;
      status_w[i2c_target_pkg::ST_RUN_BIT]  = run_ff;
      status_w[LEDS-1:0]                   = pass_ff;
   end

   assign o_sink_en = sink_ff;
   assign o_status  = status_w;

endmodule : led_self_test

// *** core/i2c_register_port.sv ***
/*
 Serial control target with register file and self-test trigger.
 Assumes open-drain link wires resolved outside from o_sda_oe, pull-ups,
 and a master clock far below the core clock.
*/
`timescale 1ns/10ps
module i2c_register_port #(
   parameter int NREGS = i2c_target_pkg::REG_COUNT,
   parameter int LEDS  = i2c_target_pkg::LED_COUNT,
   parameter int STEPS = i2c_target_pkg::STEP_EDGES
) (
   input  wire logic            i_clk,
   input  wire logic            i_rst,
   input  wire logic            i_external_reset_pin_n,
   input  wire logic            i_scl,
   input  wire logic            i_sda,
   output logic                 o_sda,
   output logic                 o_sda_oe,
   input  wire logic [LEDS-1:0] i_led_path_ok,
   output logic      [LEDS-1:0] o_test_sink_en,
   output logic                 o_bus_busy
);

   localparam int IXW = $clog2(NREGS);
   localparam int HW  = $clog2(i2c_target_pkg::HOLD_CYC + 1);

   //------------------------------------------------------------------------
   // Input synchronisation and reset merge
   //------------------------------------------------------------------------
   logic            scl_q;
   logic            sda_q;
   logic            ext_rst_n_q;
   logic [LEDS-1:0] led_ok_q;
   logic            scl_d_ff;
   logic            sda_d_ff;

   sync_two_ff #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync_pins (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async ({i_scl, i_sda, i_external_reset_pin_n}),
      .o_sync  ({scl_q, sda_q, ext_rst_n_q})
   );

   sync_two_ff #(.WIDTH(LEDS)) u_sync_led (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_led_path_ok),
      .o_sync  (led_ok_q)
   );

   wire rst_all = i_rst | ~ext_rst_n_q;

   always_ff @(posedge i_clk) begin
      if (rst_all) begin
         scl_d_ff <= scl_q;
         sda_d_ff <= sda_q;
      end else begin
         scl_d_ff <= scl_q;
         sda_d_ff <= sda_q;
      end
   end

   //------------------------------------------------------------------------
   // Link event decode
   //------------------------------------------------------------------------
   wire start_w    = scl_q & scl_d_ff & sda_d_ff & ~sda_q;
   wire stop_w     = scl_q & scl_d_ff & ~sda_d_ff & sda_q;
   wire scl_rise_w = scl_q & ~scl_d_ff;
   wire scl_fall_w = ~scl_q & scl_d_ff;

   // Output hold after clock fall before data line may change
   logic [HW-1:0] hold_cnt_ff;
   wire           fall_dly_w = (hold_cnt_ff == HW'(1));

   always_ff @(posedge i_clk) begin
      if (rst_all) begin
         hold_cnt_ff <= '0;
      end else if (scl_fall_w) begin
         hold_cnt_ff <= HW'(i2c_target_pkg::HOLD_CYC);
      end else if (hold_cnt_ff != '0) begin
         hold_cnt_ff <= hold_cnt_ff - HW'(1);
      end
   end

   //------------------------------------------------------------------------
   // Bus occupancy
   //------------------------------------------------------------------------
   logic busy_ff;

   always_ff @(posedge i_clk) begin
      if (rst_all) begin
         busy_ff <= 1'b0;
      end else if (start_w) begin
         busy_ff <= 1'b1;
      end else if (stop_w) begin
         busy_ff <= 1'b0;
      end
   end

   //------------------------------------------------------------------------
   // Register file and read selection
   //------------------------------------------------------------------------
   logic [7:0] regs_ff [NREGS];
   logic [7:0] ptr_ff;
   logic [7:0] shreg_ff;
   logic [7:0] test_status;
   logic       wr_en;

   wire        ptr_in_map = (ptr_ff < 8'(NREGS));
   wire [IXW-1:0] ptr_ix  = ptr_ff[IXW-1:0];
   wire        ptr_test   = (ptr_ff == i2c_target_pkg::REG_SELF_TEST);
   wire [7:0]  rd_data    = ptr_test   ? test_status :
                            ptr_in_map ? regs_ff[ptr_ix] : 8'h00;
   wire        test_go    = wr_en & ptr_test &
                            (shreg_ff == i2c_target_pkg::SELF_TEST_GO);

   always_ff @(posedge i_clk) begin
      if (rst_all) begin
         for (int k = 0; k < NREGS; k++) begin
            regs_ff[k] <= i2c_target_pkg::REG_RESET;
         end
      end else if (wr_en && ptr_in_map) begin
         regs_ff[ptr_ix] <= shreg_ff;
      end
   end

   led_self_test #(.LEDS(LEDS), .STEPS(STEPS)) u_self_test (
      .i_clk     (i_clk),
      .i_rst     (rst_all),
      .i_start   (test_go),
      .i_step    (scl_rise_w),
      .i_led_ok  (led_ok_q),
      .o_sink_en (o_test_sink_en),
      .o_status  (test_status)
   );

   //------------------------------------------------------------------------
   // Serial state machine
   //------------------------------------------------------------------------
   i2c_target_pkg::link_state_type state_ff;
   i2c_target_pkg::link_state_type nxt_state;
   logic [3:0] bitcnt_ff;
   logic [3:0] nxt_bitcnt;
   logic [7:0] nxt_shreg;
   logic [7:0] tx_ff;
   logic [7:0] nxt_tx;
   logic [7:0] nxt_ptr;
   logic       mack_ff;
   logic       nxt_mack;
   logic       oe_ff;
   logic       nxt_oe;

   wire byte_done = fall_dly_w & (bitcnt_ff == i2c_target_pkg::BYTE_BITS);
   wire addr_hit  = (shreg_ff[7:1] == i2c_target_pkg::DEV_ADDR);
   wire dir_read  = (shreg_ff[0] == i2c_target_pkg::DIR_READ);

   always_comb begin
      nxt_state  = state_ff;
      nxt_bitcnt = bitcnt_ff;
      nxt_shreg  = shreg_ff;
      nxt_tx     = tx_ff;
      nxt_ptr    = ptr_ff;
      nxt_mack   = mack_ff;
      wr_en      = 1'b0;
      if (start_w) begin
         nxt_state  = i2c_target_pkg::ST_ADDR;
         nxt_bitcnt = 4'h0;
      end else if (stop_w) begin
         nxt_state  = i2c_target_pkg::ST_IDLE;
         nxt_bitcnt = 4'h0;
      end else begin
         case (state_ff)
            i2c_target_pkg::ST_ADDR,
            i2c_target_pkg::ST_REG,
            i2c_target_pkg::ST_WDATA: begin
               if (scl_rise_w) begin
                  nxt_shreg  = {shreg_ff[6:0], sda_q};
                  nxt_bitcnt = bitcnt_ff + 4'h1;
               end
               if (byte_done) begin
                  nxt_bitcnt = 4'h0;
                  case (state_ff)
                     i2c_target_pkg::ST_ADDR: begin
                        nxt_state = addr_hit ?
                           i2c_target_pkg::ST_ADDR_ACK :
                           i2c_target_pkg::ST_IGNORE;
                     end
                     i2c_target_pkg::ST_REG: begin
                        nxt_state = i2c_target_pkg::ST_REG_ACK;
                        nxt_ptr   = shreg_ff;
                     end
                     default: begin
                        nxt_state = i2c_target_pkg::ST_WDATA_ACK;
                        wr_en     = 1'b1;
                     end
                  endcase
               end
            end
            i2c_target_pkg::ST_ADDR_ACK: begin
               if (fall_dly_w) begin
                  if (dir_read) begin
                     nxt_state = i2c_target_pkg::ST_RDATA;
                     nxt_tx    = rd_data;
                  end else begin
                     nxt_state = i2c_target_pkg::ST_REG;
                  end
               end
            end
            i2c_target_pkg::ST_REG_ACK,
            i2c_target_pkg::ST_WDATA_ACK: begin
               if (fall_dly_w) begin
                  nxt_state = i2c_target_pkg::ST_WDATA;
               end
            end
            i2c_target_pkg::ST_RDATA: begin
               if (scl_rise_w) begin
                  nxt_bitcnt = bitcnt_ff + 4'h1;
               end
               if (byte_done) begin
                  nxt_bitcnt = 4'h0;
                  nxt_state  = i2c_target_pkg::ST_RDATA_ACK;
               end else if (fall_dly_w && bitcnt_ff != 4'h0) begin
                  nxt_tx = {tx_ff[6:0], 1'b0};
               end
            end
            i2c_target_pkg::ST_RDATA_ACK: begin
               if (scl_rise_w) begin
                  nxt_mack = ~sda_q;
               end
               if (fall_dly_w) begin
                  if (mack_ff) begin
                     nxt_state = i2c_target_pkg::ST_RDATA;
                     nxt_tx    = rd_data;
                  end else begin
                     nxt_state = i2c_target_pkg::ST_IGNORE;
                  end
               end
            end
            i2c_target_pkg::ST_IDLE,
            i2c_target_pkg::ST_IGNORE: begin
               nxt_bitcnt = 4'h0;
            end
            default: begin
               nxt_state  = i2c_target_pkg::ST_IDLE;
               nxt_bitcnt = 4'h0;
            end
         endcase
      end
   end

   // Data line only ever pulled low; never on a high clock edge of its own
   always_comb begin
      case (nxt_state)
         i2c_target_pkg::ST_ADDR_ACK,
         i2c_target_pkg::ST_REG_ACK,
         i2c_target_pkg::ST_WDATA_ACK: nxt_oe = 1'b1;
         i2c_target_pkg::ST_RDATA:     nxt_oe = ~nxt_tx[7];
         default:                      nxt_oe = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (rst_all) begin
         state_ff  <= i2c_target_pkg::ST_IDLE;
         bitcnt_ff <= 4'h0;
         shreg_ff  <= 8'h00;
         tx_ff     <= 8'h00;
         ptr_ff    <= 8'h00;
         mack_ff   <= 1'b0;
         oe_ff     <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         bitcnt_ff <= nxt_bitcnt;
         shreg_ff  <= nxt_shreg;
         tx_ff     <= nxt_tx;
         ptr_ff    <= nxt_ptr;
         mack_ff   <= nxt_mack;
         oe_ff     <= nxt_oe;
      end
   end

   assign o_sda      = 1'b0;
   assign o_sda_oe   = oe_ff;
   assign o_bus_busy = busy_ff;

endmodule : i2c_register_port

// *** dv/i2c_port_props.sv ***
/*
 Checker of the serial control target, watching only the top's ports.
 Assumes it is bound to i2c_register_port with LEDS handed on.
*/
`timescale 1ns/10ps
module i2c_port_props #(
   parameter int LEDS = 5
) (
   input wire logic            i_clk,
   input wire logic            i_rst,
   input wire logic            i_external_reset_pin_n,
   input wire logic            i_scl,
   input wire logic            i_sda,
   input wire logic            o_sda,
   input wire logic            o_sda_oe,
   input wire logic [LEDS-1:0] i_led_path_ok,
   input wire logic [LEDS-1:0] o_test_sink_en,
   input wire logic            o_bus_busy
);
   //------------------------------------------------------------------------
   // Line sampling and event ages
   //------------------------------------------------------------------------
   function automatic logic [3:0] sat(input logic [3:0] v);
      return v + {3'h0, v != 4'hf};
   endfunction : sat

   logic [2:0] scl_ff;
   logic [2:0] sda_ff;
   logic [3:0] start_age_ff;
   logic [3:0] fall_age_ff;
   logic [3:0] rise_age_ff;
   wire        hi_both       = scl_ff[1] & scl_ff[2];
   wire        start_ev      = hi_both & sda_ff[2] & ~sda_ff[1];
   wire        stop_ev       = hi_both & ~sda_ff[2] & sda_ff[1];
   wire        fall_ev       = scl_ff[2] & ~scl_ff[1];
   wire        rise_ev       = ~scl_ff[2] & scl_ff[1];
   wire  [2:0] nxt_scl       = {scl_ff[1:0], i_scl};
   wire  [2:0] nxt_sda       = {sda_ff[1:0], i_sda};
   wire  [3:0] nxt_start_age = start_ev ? 4'h0 : sat(start_age_ff);
   wire  [3:0] nxt_fall_age  = fall_ev ? 4'h0 : sat(fall_age_ff);
   wire  [3:0] nxt_rise_age  = rise_ev ? 4'h0 : sat(rise_age_ff);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         scl_ff       <= 3'h7;
         sda_ff       <= 3'h7;
         start_age_ff <= 4'hf;
         fall_age_ff  <= 4'hf;
         rise_age_ff  <= 4'hf;
      end else begin
         scl_ff       <= nxt_scl;
         sda_ff       <= nxt_sda;
         start_age_ff <= nxt_start_age;
         fall_age_ff  <= nxt_fall_age;
         rise_age_ff  <= nxt_rise_age;
      end
   end

   //------------------------------------------------------------------------
   // Properties
   //------------------------------------------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst || !i_external_reset_pin_n);

   chk_start_busy: assert property (start_ev |-> ##[0:3] o_bus_busy)
      else $error("bus not busy after start");
   chk_stop_idle: assert property (stop_ev |-> ##[0:3] !o_bus_busy)
      else $error("bus still busy after stop");
   chk_busy_cause: assert property (
      $rose(o_bus_busy) |-> start_age_ff <= 4'h4)
      else $error("busy raised without a start");
   chk_quiet_idle: assert property (!o_bus_busy [*2] |-> !o_sda_oe)
      else $error("data driven on an idle bus");
   chk_sda_change_low: assert property (
      $changed(o_sda_oe) |-> !scl_ff[1])
      else $error("data drive changed while clock high");
   chk_oe_hold_time: assert property (
      $rose(o_sda_oe) |-> fall_age_ff inside {[4'h9:4'he]})
      else $error("data drive not at hold delay after fall");
   chk_pin_reset: assert property (disable iff (i_rst)
      !i_external_reset_pin_n [*4] |->
         !o_bus_busy && !o_sda_oe && o_test_sink_en == '0)
      else $error("outputs active in pin reset");
   chk_sink_onehot: assert property ($onehot0(o_test_sink_en))
      else $error("more than one test sink on");
   chk_sink_step: assert property (
      $changed(o_test_sink_en) && $past(o_test_sink_en) != '0
         |-> rise_age_ff <= 4'h5)
      else $error("test sink moved away from clock rise");

   cov_ack: cover property ($rose(o_sda_oe));
   cov_stop: cover property (stop_ev && o_bus_busy);
   cov_last_sink: cover property (o_test_sink_en[LEDS-1]);
endmodule : i2c_port_props

bind i2c_register_port i2c_port_props #(
   .LEDS(LEDS)
) u_port_props (
   .i_clk,
   .i_rst,
   .i_external_reset_pin_n,
   .i_scl,
   .i_sda,
   .o_sda,
   .o_sda_oe,
   .i_led_path_ok,
   .o_test_sink_en,
   .o_bus_busy
);

// *** dv/i2c_host_model.sv ***
/*
 Host bus master model: start, stop, byte write and byte read tasks.
 Assumes a pull-up on the data wire, resolved by the bench.
*/
`timescale 1ns/10ps
module i2c_host_model #(
   parameter int LOW_NS  = 1300,
   parameter int HIGH_NS = 1200
) (
   input  wire logic i_sda_line,
   output logic      o_scl,
   output logic      o_sda_pull
);
   //------------------------------------------------------------------------
   // Bus cycles
   //------------------------------------------------------------------------
   // Phase lengths, slowed by the bench while the self-test runs
   int low_ns  = LOW_NS;
   int high_ns = HIGH_NS;

   initial begin
      o_scl      = 1'b1;
      o_sda_pull = 1'b0;
   end

   // Period kept at 400 kHz or slower
   task automatic clk_bit(input logic b, output logic s);
      #(low_ns/2) o_sda_pull = ~b;
      #(low_ns/2) o_scl = 1'b1;
      #(high_ns/2) s = i_sda_line;
      #(high_ns/2) o_scl = 1'b0;
   endtask : clk_bit

   task automatic bus_start();
      if (o_scl === 1'b0) begin
         #(low_ns/2) o_sda_pull = 1'b0;
         #(low_ns/2) o_scl = 1'b1;
      end
      #(high_ns/2) o_sda_pull = 1'b1;
      #(high_ns/2) o_scl = 1'b0;
   endtask : bus_start

   task automatic bus_stop();
      #(low_ns/2) o_sda_pull = 1'b1;
      #(low_ns/2) o_scl = 1'b1;
      #(high_ns/2) o_sda_pull = 1'b0;
      #(low_ns);
   endtask : bus_stop

   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(b[i], s);
      end
      clk_bit(1'b1, s);
      ack = ~s;
   endtask : put_byte

   task automatic get_byte(output logic [7:0] b, input logic ack);
      logic s;
      for (int i = 0; i < 8; i++) begin
         clk_bit(1'b1, s);
         b = {b[6:0], s};
      end
      clk_bit(~ack, s);
   endtask : get_byte
endmodule : i2c_host_model

// *** dv/i2c_register_port_with_self_test_bench.sv ***
/*
 Self-checking bench of the serial control target and its self-test.
 Assumes the host model drives the link; the bench resolves the wire.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) \
   begin \
      comparisons++; \
      if ((g) !== (e)) begin \
         error_cnt++; \
         $display("[ERR] %s expected %h seen %h", nm, e, g); \
      end \
   end
module i2c_register_port_with_self_test_bench;
   //------------------------------------------------------------------------
   // Stimulus, tasks and scenarios
   //------------------------------------------------------------------------
   localparam logic [7:0] WADDR = {i2c_target_pkg::DEV_ADDR, 1'b0};
   localparam logic [7:0] RADDR = {i2c_target_pkg::DEV_ADDR, 1'b1};
   logic       i_clk = 1'b0;
   logic       i_rst = 1'b1;
   logic       i_external_reset_pin_n = 1'b1;
   logic [4:0] i_led_path_ok = 5'h00;
   logic [4:0] o_test_sink_en;
   logic       o_sda;
   logic       o_sda_oe;
   logic       o_bus_busy;
   logic       scl;
   logic       sda_pull;
   wire        sda_line = (o_sda_oe ? o_sda : 1'b1) & ~sda_pull;
   int         error_cnt = 0;
   int         comparisons = 0;
   logic       ack;
   logic       s;
   logic [7:0] rd_val;

   always #12.5 i_clk = ~i_clk;

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic wr(input logic [7:0] rg, input logic [7:0] dt);
      m.bus_start();
      m.put_byte(WADDR, ack);
      `CHK("write addr ack", 1'b1, ack)
      m.put_byte(rg, ack);
      `CHK("reg ack", 1'b1, ack)
      m.put_byte(dt, ack);
      `CHK("data ack", 1'b1, ack)
      m.bus_stop();
   endtask : wr

   task automatic rd(input logic [7:0] rg, input logic [7:0] exp);
      m.bus_start();
      `CHK("busy after start", 1'b1, o_bus_busy)
      m.put_byte(WADDR, ack);
      m.put_byte(rg, ack);
      m.bus_start();
      m.put_byte(RADDR, ack);
      `CHK("read addr ack", 1'b1, ack)
      m.get_byte(rd_val, 1'b0);
      `CHK("read data", exp, rd_val)
      m.bus_stop();
      `CHK("idle after stop", 1'b0, o_bus_busy)
   endtask : rd

   task automatic t_reset_state();
      `CHK("busy at reset", 1'b0, o_bus_busy)
      `CHK("drive at reset", 1'b0, o_sda_oe)
      `CHK("data value", 1'b0, o_sda)
      rd(8'h03, 8'h00);
      rd(8'h20, 8'h00);
   endtask : t_reset_state

   task automatic t_write_read();
      wr(8'h05, 8'ha5);
      m.bus_start();
      m.put_byte(WADDR, ack);
      m.put_byte(8'h0a, ack);
      m.put_byte(8'h3c, ack);
      m.put_byte(8'h5a, ack);
      `CHK("second data ack", 1'b1, ack)
      m.bus_stop();
      rd(8'h05, 8'ha5);
      rd(8'h0a, 8'h5a);
      rd(8'h0b, 8'h00);
   endtask : t_write_read

   task automatic t_wrong_addr();
      m.bus_start();
      m.put_byte(8'h9a, ack);
      `CHK("foreign addr nack", 1'b0, ack)
      m.put_byte(8'h05, ack);
      m.put_byte(8'h00, ack);
      `CHK("ignored byte nack", 1'b0, ack)
      `CHK("busy while ignoring", 1'b1, o_bus_busy)
      m.bus_stop();
      rd(8'h05, 8'ha5);
   endtask : t_wrong_addr

   task automatic t_abort();
      m.bus_start();
      m.put_byte(WADDR, ack);
      m.put_byte(8'h05, ack);
      for (int i = 0; i < 4; i++) begin
         m.clk_bit(1'b0, s);
      end
      m.bus_stop();
      rd(8'h05, 8'ha5);
      m.bus_start();
      m.put_byte(WADDR, ack);
      @(posedge i_clk);
      i_external_reset_pin_n <= 1'b0;
      repeat (10) @(posedge i_clk);
      `CHK("busy in pin reset", 1'b0, o_bus_busy)
      `CHK("drive in pin reset", 1'b0, o_sda_oe)
      i_external_reset_pin_n <= 1'b1;
      repeat (6) @(posedge i_clk);
      m.bus_stop();
      rd(8'h05, 8'h00);
   endtask : t_abort

   task automatic t_self_test();
      @(posedge i_clk);
      i_led_path_ok <= 5'h16;
      m.low_ns  = 10000;
      m.high_ns = 10000;
      // Enables and test pins live outside this block
      wr(i2c_target_pkg::REG_SELF_TEST, i2c_target_pkg::SELF_TEST_GO);
      `CHK("sink during test", 5'h02, o_test_sink_en)
      m.bus_start();
      m.put_byte(8'h9a, ack);
      `CHK("slow foreign nack", 1'b0, ack)
      m.bus_stop();
      m.low_ns  = 1300;
      m.high_ns = 1200;
      rd(8'h0c, 8'h96);
      `CHK("sinks off after test", 5'h00, o_test_sink_en)
   endtask : t_self_test

   initial begin
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (6) @(posedge i_clk);
      t_reset_state();
      t_write_read();
      t_wrong_addr();
      t_abort();
      t_self_test();
      print_verdict();
   end

   initial begin
      #2300000;
      error_cnt++;
      $display("[ERR] watchdog expected done seen timeout");
      print_verdict();
   end

   i2c_register_port #(
      .STEPS(2)
   ) DUT (
      .i_clk                  (i_clk),
      .i_rst                  (i_rst),
      .i_external_reset_pin_n (i_external_reset_pin_n),
      .i_scl                  (scl),
      .i_sda                  (sda_line),
      .o_sda                  (o_sda),
      .o_sda_oe               (o_sda_oe),
      .i_led_path_ok          (i_led_path_ok),
      .o_test_sink_en         (o_test_sink_en),
      .o_bus_busy             (o_bus_busy)
   );

   i2c_host_model m (
      .i_sda_line (sda_line),
      .o_scl      (scl),
      .o_sda_pull (sda_pull)
   );
endmodule : i2c_register_port_with_self_test_bench
